/* File: swe_cmd.sv */
// Command handling for page writes, security register writes, lock and
// speed mode inside a single-wire EEPROM, plus the commit FIFO.
// Assumes a bit layer on clk that delivers start, stop and bit pulses,
// and a nonvolatile engine that drains the FIFO and keeps the lock bit.
`timescale 1ns/1ns
`default_nettype none
`include "swe_cfg.svh"

// ----------------------------------------------------------------------------
// Commit FIFO
// ----------------------------------------------------------------------------
module swe_fifo
  import swe_pkg::*;
#(
  parameter int WIDTH = `SWE_FIFO_WIDTH,
  parameter int DEPTH = `SWE_FIFO_DEPTH
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  swe_fifo_s  st_r;
  swe_fifo_s  st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic       full;
  logic       empty;
  // Pointer one bit wider than the index tells full from empty
  assign empty    = (st_r.wrPtr == st_r.rdPtr);
  assign full     = (st_r.wrPtr[AW] != st_r.rdPtr[AW]) &&
                    (st_r.wrPtr[AW-1:0] == st_r.rdPtr[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[st_r.rdPtr[AW-1:0]];

  // Pointer update; flush drops everything not yet drained
  always_comb
  begin
    st_nxt = st_r;
    if (inValid && !full && !flush)
      st_nxt.wrPtr = st_r.wrPtr + 5'h01;
    if (outReady && !empty)
      st_nxt.rdPtr = st_r.rdPtr + 5'h01;
    if (flush)
      st_nxt.rdPtr = st_r.wrPtr;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Storage needs no reset, only written entries are ever read
  always_ff @(posedge clk)
  begin
    if (inValid && !full && !flush)
      mem[st_r.wrPtr[AW-1:0]] <= inData;
  end
endmodule

// ----------------------------------------------------------------------------
// Command sequencer
// ----------------------------------------------------------------------------
module swe_cmd
  import swe_pkg::*;
#(
  parameter int   WR_CYCLES = `SWE_WR_CYCLES,
  parameter bit   HAS_SLOW  = 1'b1
)(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] slaveAddr,
  input  wire logic       startSeen,
  input  wire logic       stopSeen,
  input  wire logic       bitValid,
  input  wire logic       bitData,
  input  wire logic       linePulse,
  input  wire logic       dischargeAbort,
  input  wire logic       discoveryReset,
  input  wire logic       secLockedNv,
  output logic            ackValid,
  output logic            respNack,
  output logic            speedSlow,
  output logic            writeBusy,
  output logic            lockProgram,
  output logic            wrAbort,
  output logic            nvmValid,
  input  wire logic       nvmReady,
  output logic            nvmSec,
  output logic [6:0]      nvmAddr,
  output logic [7:0]      nvmData
);
  localparam logic [16:0] WR_LOAD = 17'(WR_CYCLES - 1);
  swe_st_s     st_r;
  swe_st_s     st_nxt;
  logic        byteDone;
  logic [7:0]  rxByte;
  logic [3:0]  op;
  logic        isRead;
  logic        saMatch;
  logic        fifoReady;
  logic        fifoValid;
  logic [15:0] fifoOut;
  logic        cycling;

  // Byte assembly, MSB first; address byte layout
  assign byteDone = bitValid && (st_r.bitCnt == 3'h7);
  assign rxByte   = {st_r.shift[6:0], bitData};
  assign op       = rxByte[`SWE_OP_HI:`SWE_OP_LO];
  assign isRead   = rxByte[`SWE_RW_BIT];
  assign saMatch  = (rxByte[`SWE_SA_HI:`SWE_SA_LO] == slaveAddr);
  assign cycling  = (st_r.state == SW_COMMIT) || (st_r.state == SW_BUSY);
  assign ackValid    = st_r.ackValid;
  assign respNack    = st_r.respNack;
  assign speedSlow   = st_r.slow;
  assign writeBusy   = cycling;
  assign lockProgram = st_r.lockProgram;
  assign wrAbort     = st_r.wrAbort;
  assign nvmValid    = fifoValid;
  assign nvmSec      = fifoOut[15];
  assign nvmAddr     = fifoOut[14:8];
  assign nvmData     = fifoOut[7:0];

  // Bytes reach memory only through this FIFO; a stalled engine holds the cycle in SW_BUSY until it drains
  swe_fifo #(.WIDTH(`SWE_FIFO_WIDTH), .DEPTH(`SWE_FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .flush    (st_r.wrAbort),
    .inValid  (st_r.push),
    .inReady  (fifoReady),
    .inData   (st_r.pushData),
    .outValid (fifoValid),
    .outReady (nvmReady),
    .outData  (fifoOut)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    st_nxt             = st_r;
    st_nxt.ackValid    = 1'b0;
    st_nxt.lockProgram = 1'b0;
    st_nxt.wrAbort     = 1'b0;
    st_nxt.push        = st_r.push && !fifoReady;
    if (bitValid)
      st_nxt.shift = rxByte;
    if (bitValid && !cycling)
      st_nxt.bitCnt = st_r.bitCnt + 3'h1;
    if (discoveryReset)
      st_nxt.slow = `SWE_SLOW_RESET;
    if (cycling)
    begin
      // Bus ignored while programming; a short pulse is answered NACK
      st_nxt.bitCnt = 3'h0;
      if (linePulse)
      begin
        st_nxt.ackValid = 1'b1;
        st_nxt.respNack = 1'b1;
      end
      if (st_r.timer != 17'h0)
        st_nxt.timer = st_r.timer - 17'h1;
      if (dischargeAbort)
      begin
        // Pending FIFO words are dropped, so untouched pages stay intact
        st_nxt.wrAbort  = 1'b1;
        st_nxt.lockPend = 1'b0;
        st_nxt.push     = 1'b0;
        st_nxt.state    = SW_IDLE;
      end
      else if (st_r.state == SW_COMMIT)
      begin
        if (!st_nxt.push)
        begin
          if (st_r.idx[3])
            st_nxt.state = SW_BUSY;
          else
          begin
            st_nxt.push     = st_r.mask[st_r.idx[2:0]];
            st_nxt.pushData = {st_r.target == TG_SEC, st_r.addr[6:3],
                               st_r.idx[2:0], st_r.page[st_r.idx[2:0]]};
            st_nxt.idx      = st_r.idx + 4'h1;
          end
        end
      end
      else if (st_r.timer == 17'h0 && !fifoValid && !st_r.push)
      begin
        // Lock becomes permanent only once the full cycle has run
        st_nxt.lockProgram = st_r.lockPend;
        st_nxt.lockPend    = 1'b0;
        st_nxt.state       = SW_IDLE;
      end
    end
    else if (startSeen)
    begin
      st_nxt.bitCnt = 3'h0;
      st_nxt.mask   = 8'h00;
      st_nxt.state  = SW_DEVADDR;
    end
    else if (stopSeen)
    begin
      st_nxt.bitCnt = 3'h0;
      st_nxt.state  = SW_IDLE;
      if (st_r.bitCnt != 3'h0)
        st_nxt.mask = 8'h00;
      else if (st_r.state == SW_DATA && st_r.mask != 8'h00)
      begin
        // Whole bytes only: program the loaded page
        st_nxt.state = SW_COMMIT;
        st_nxt.idx   = 4'h0;
        st_nxt.timer = WR_LOAD;
      end
      else if (st_r.state == SW_LOCKARMED)
      begin
        st_nxt.state    = SW_COMMIT;
        st_nxt.idx      = 4'h8;
        st_nxt.lockPend = 1'b1;
        st_nxt.timer    = WR_LOAD;
      end
    end
    else if (byteDone)
    begin
      st_nxt.ackValid = 1'b1;
      st_nxt.respNack = 1'b1;
      st_nxt.state    = SW_IGNORE;
      case (st_r.state)
        SW_DEVADDR:
        begin
          if (saMatch)
          begin
            case (op)
              `SWE_OP_MAIN, `SWE_OP_SEC, `SWE_OP_LOCK:
              begin
                if (!isRead)
                begin
                  st_nxt.respNack = 1'b0;
                  st_nxt.state    = SW_MEMADDR;
                  st_nxt.target   = (op == `SWE_OP_MAIN) ? TG_MAIN :
                                    (op == `SWE_OP_SEC) ? TG_SEC : TG_LOCK;
                end
              end
              `SWE_OP_SLOW:
              begin
                st_nxt.respNack = isRead ? !(HAS_SLOW && st_r.slow) : !HAS_SLOW;
                if (!isRead && HAS_SLOW)
                  st_nxt.slow = 1'b1;
              end
              `SWE_OP_FAST:
              begin
                st_nxt.respNack = isRead && st_r.slow;
                if (!isRead)
                  st_nxt.slow = 1'b0;
              end
              default: st_nxt.respNack = 1'b1;
            endcase
          end
        end
        SW_MEMADDR:
        begin
          if (st_r.target == TG_LOCK)
          begin
            // Lock and lock check share this answer
            if (rxByte[7:4] == `SWE_LOCK_ADDR && !secLockedNv)
            begin
              st_nxt.respNack = 1'b0;
              st_nxt.state    = SW_LOCKDATA;
            end
          end
          else
          begin
            st_nxt.respNack = 1'b0;
            st_nxt.state    = SW_DATA;
            st_nxt.addr     = (st_r.target == TG_SEC) ?
                              {2'b00, rxByte[4:0]} : rxByte[6:0];
          end
        end
        SW_DATA:
        begin
          if (st_r.target == TG_SEC &&
              (secLockedNv || !st_r.addr[`SWE_SEC_USER_BIT]))
            st_nxt.state = SW_IDLE;
          else
          begin
            st_nxt.respNack                 = 1'b0;
            st_nxt.state                    = SW_DATA;
            st_nxt.page[st_r.addr[2:0]]     = rxByte;
            st_nxt.mask[st_r.addr[2:0]]     = 1'b1;
            st_nxt.addr[2:0]                = st_r.addr[2:0] + 3'h1;
          end
        end
        SW_LOCKDATA:
        begin
          st_nxt.respNack = 1'b0;
          st_nxt.state    = SW_LOCKARMED;
        end
        default: st_nxt.respNack = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r       <= '0;
      st_r.slow  <= `SWE_SLOW_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_idleCmd;
    !cycling && !startSeen && !stopSeen && byteDone;
  endsequence
  sequence s_devByte(logic [3:0] o, logic r);
    s_idleCmd ##0 (st_r.state == SW_DEVADDR) && saMatch && op == o && isRead == r;
  endsequence
  sequence s_goodStop;
    !cycling && !startSeen && stopSeen && st_r.bitCnt == 3'h0 &&
    st_r.state == SW_DATA && st_r.mask != 8'h00;
  endsequence

  a_discovery_fast: assert property (discoveryReset |=> !speedSlow)
    else $error("discovery reset left slow mode");
  a_slow_select: assert property (s_devByte(`SWE_OP_SLOW, 1'b0) |=>
      ackValid && (respNack == !HAS_SLOW) && (speedSlow == HAS_SLOW))
    else $error("slow mode select wrong");
  a_fast_select: assert property (s_devByte(`SWE_OP_FAST, 1'b0) |=>
      ackValid && !respNack && !speedSlow)
    else $error("fast mode select wrong");
  a_fast_query: assert property (s_devByte(`SWE_OP_FAST, 1'b1) |=>
      ackValid && respNack == $past(st_r.slow))
    else $error("fast mode query wrong");
  a_bad_stop: assert property (!cycling && !startSeen && stopSeen &&
      st_r.bitCnt != 3'h0 |=> !writeBusy ##1 !writeBusy)
    else $error("partial byte started programming");
  a_busy_nack: assert property (cycling && linePulse |=> ackValid && respNack)
    else $error("pulse in write cycle not NACKed");
  a_locked_data: assert property (s_idleCmd ##0 st_r.state == SW_DATA &&
      st_r.target == TG_SEC && secLockedNv |=> respNack && st_r.state == SW_IDLE)
    else $error("locked security write not refused");
  a_page_wrap: assert property (s_idleCmd ##0 st_r.state == SW_DATA &&
      st_r.target == TG_MAIN |=> st_r.addr[6:3] == $past(st_r.addr[6:3]) &&
      st_r.addr[2:0] == $past(st_r.addr[2:0]) + 3'h1)
    else $error("page address increment wrong");
  a_stop_busy: assert property (s_goodStop ##1 !dischargeAbort[*8] |->
      writeBusy)
    else $error("write cycle ended too early");
  a_lock_check: assert property (s_idleCmd ##0 st_r.state == SW_MEMADDR &&
      st_r.target == TG_LOCK && rxByte[7:4] == `SWE_LOCK_ADDR |=>
      ackValid && respNack == $past(secLockedNv))
    else $error("lock check answer wrong");
endmodule

`default_nettype wire

/* File: swe_cfg.svh */
// Constants of the single-wire EEPROM write, lock and speed command block.
// Assumes inclusion by the package and by the command block; definitions only.
`ifndef SWE_CFG_SVH
`define SWE_CFG_SVH

// ----------------------------------------------------------------------------
// Opcodes in the upper nibble of the device address byte; lock address nibble of the memory address byte
// ----------------------------------------------------------------------------
`define SWE_OP_MAIN      4'hA
`define SWE_OP_SEC       4'hB
`define SWE_OP_LOCK      4'h2
`define SWE_OP_SLOW      4'hD
`define SWE_OP_FAST      4'hE
`define SWE_LOCK_ADDR    4'h6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SWE_OP_HI        7
`define SWE_OP_LO        4
`define SWE_SA_HI        3
`define SWE_SA_LO        1
`define SWE_RW_BIT       0
`define SWE_SEC_USER_BIT 4

// ----------------------------------------------------------------------------
// Timing and sizes
// ----------------------------------------------------------------------------
`define SWE_CLK_MHZ      25
`define SWE_WR_TIME_US   5000
`define SWE_WR_CYCLES    (`SWE_WR_TIME_US * `SWE_CLK_MHZ)
`define SWE_FIFO_DEPTH   16
`define SWE_FIFO_WIDTH   16
`define SWE_SLOW_RESET   1'b0

`endif

/* File: swe_pkg.sv */
// Types of the single-wire EEPROM write, lock and speed command block.
// Assumes the constants header sits in the same folder.
`include "swe_cfg.svh"

package swe_pkg;

  // --------------------------------------------------------------------------
  // Command sequencer states and write targets
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SW_IDLE, SW_DEVADDR, SW_MEMADDR, SW_DATA, SW_LOCKDATA,
    SW_LOCKARMED, SW_IGNORE, SW_COMMIT, SW_BUSY
  } swe_state_e;

  typedef enum logic [1:0] {TG_MAIN, TG_SEC, TG_LOCK} swe_target_e;

  // --------------------------------------------------------------------------
  // Whole sequencer state
  // --------------------------------------------------------------------------
  typedef struct packed {
    swe_state_e       state;
    swe_target_e      target;
    logic [2:0]       bitCnt;
    logic [7:0]       shift;
    logic [6:0]       addr;
    logic [7:0][7:0]  page;
    logic [7:0]       mask;
    logic [3:0]       idx;
    logic             slow;
    logic             lockPend;
    logic [16:0]      timer;
    logic             ackValid;
    logic             respNack;
    logic             lockProgram;
    logic             wrAbort;
    logic             push;
    logic [15:0]      pushData;
  } swe_st_s;

  typedef struct packed {
    logic [4:0] wrPtr;
    logic [4:0] rdPtr;
  } swe_fifo_s;

endpackage

/* File: swe_master.sv */
// Bus master model: turns byte requests into start, bit and stop pulses.
// Assumes the command sequencer answers on ackValid within four cycles.
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Master model
// ----------------------------------------------------------------------------
module swe_master (
  input  wire logic clk,
  input  wire logic ackValid,
  input  wire logic respNack,
  output logic      startSeen,
  output logic      stopSeen,
  output logic      bitValid,
  output logic      bitData,
  output logic      linePulse
);
  // Line released at time zero
  initial
  begin
    startSeen = 1'b0;
    stopSeen  = 1'b0;
    bitValid  = 1'b0;
    bitData   = 1'b1;
    linePulse = 1'b0;
  end

  // Start or stop frame; a stop is only a release of the line
  task automatic frame(input logic isStart);
    @(negedge clk);
    startSeen = isStart;
    stopSeen  = ~isStart;
    @(negedge clk);
    startSeen = 1'b0;
    stopSeen  = 1'b0;
  endtask

  // Short low pulse that leaves the stored charge intact
  task automatic pulse();
    @(negedge clk);
    linePulse = 1'b1;
    @(negedge clk);
    linePulse = 1'b0;
  endtask

  // MSB first; a short count leaves the byte open to test aborts
  task automatic sendBits(input logic [7:0] b, input int cnt, output logic nack);
    int k;
    nack = 1'bx;
    for (int i = 7; i > 7 - cnt; i--)
    begin
      @(negedge clk);
      bitValid = 1'b1;
      bitData  = b[i];
    end
    @(negedge clk);
    bitValid = 1'b0;
    bitData  = ~bitData;
    // Released data line shows the inverse, not a stale copy
    for (k = 0; k < 4 && cnt == 8 && ackValid !== 1'b1; k++)
      @(negedge clk);
    if (ackValid === 1'b1)
      nack = respNack;
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench of the command sequencer with an engine stand-in.
// Assumes swe_pkg, swe_cmd and swe_master are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module tb
  import swe_pkg::*;
;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  localparam logic [2:0] SA = 3'h5;
  localparam logic [3:0] SP_OP [6] = '{4'hD, 4'hD, 4'hE, 4'hE, 4'hE, 4'hD};
  localparam logic [5:0] SP_RW = 6'b110110;
  localparam logic [5:0] SP_NK = 6'b100100;
  localparam logic [5:0] SP_SL = 6'b000111;
  logic        clk, reset_n, secLockedNv, dischargeAbort, discoveryReset, nvmReady;
  logic        startSeen, stopSeen, bitValid, bitData, linePulse;
  logic        ackValid, respNack, speedSlow, writeBusy, lockProgram, wrAbort;
  logic        nvmValid, nvmSec, n, lp;
  logic [6:0]  nvmAddr;
  logic [2:0]  slaveAddr;
  logic [7:0]  nvmData;
  logic [15:0] words[$];
  int          failures, checks;

  // Short write cycle keeps the run brief
  swe_cmd #(.WR_CYCLES(20), .HAS_SLOW(1'b1)) u_swe_cmd (
    .clk            (clk),
    .reset_n        (reset_n),
    .slaveAddr      (slaveAddr),
    .startSeen      (startSeen),
    .stopSeen       (stopSeen),
    .bitValid       (bitValid),
    .bitData        (bitData),
    .linePulse      (linePulse),
    .dischargeAbort (dischargeAbort),
    .discoveryReset (discoveryReset),
    .secLockedNv    (secLockedNv),
    .ackValid       (ackValid),
    .respNack       (respNack),
    .speedSlow      (speedSlow),
    .writeBusy      (writeBusy),
    .lockProgram    (lockProgram),
    .wrAbort        (wrAbort),
    .nvmValid       (nvmValid),
    .nvmReady       (nvmReady),
    .nvmSec         (nvmSec),
    .nvmAddr        (nvmAddr),
    .nvmData        (nvmData)
  );
  swe_master u_swe_master (
    .clk       (clk),
    .ackValid  (ackValid),
    .respNack  (respNack),
    .startSeen (startSeen),
    .stopSeen  (stopSeen),
    .bitValid  (bitValid),
    .bitData   (bitData),
    .linePulse (linePulse)
  );

  // Clock and engine stand-in that logs every word taken
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk)
    if (reset_n && nvmValid === 1'b1 && nvmReady)
      words.push_back({nvmSec, nvmAddr, nvmData});

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic conclude();
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tx(input logic [7:0] b, input logic expNack);
    u_swe_master.sendBits(b, 8, n);
    chk({15'h0, n}, {15'h0, expNack}, "answer");
  endtask

  // Bounded wait for the end of the write cycle; notes lockProgram there
  task automatic waitDone();
    lp = 1'b0;
    for (int k = 0; k < 200 && writeBusy !== 1'b0; k++)
    begin
      @(negedge clk);
      lp = lockProgram;
    end
    chk({15'h0, writeBusy}, 16'h0, "busy end");
  endtask

  task automatic idleChk();
    repeat (5) @(negedge clk);
    chk({15'h0, writeBusy}, 16'h0, "no cycle");
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Wrapping page write with the engine stalled; commit in page order
  task automatic sPage();
    nvmReady = 1'b0;
    words.delete();
    u_swe_master.frame(1'b1);
    tx({4'hA, SA, 1'b0}, 1'b0);
    tx(8'h9E, 1'b0);
    tx(8'hD0, 1'b0);
    tx(8'hD1, 1'b0);
    tx(8'hD2, 1'b0);
    u_swe_master.frame(1'b0);
    repeat (10) @(negedge clk);
    chk({14'h0, writeBusy, nvmValid}, 16'h3, "commit");
    nvmReady = 1'b1;
    waitDone();
    chk(16'(words.size()), 16'h3, "count");
    chk(words[0], 16'h18D2, "w0");
    chk(words[1], 16'h1ED0, "w1");
    chk(words[2], 16'h1FD1, "w2");
  endtask

  // Stop inside a byte, and a foreign slave address
  task automatic sAbort();
    u_swe_master.frame(1'b1);
    tx({4'hA, SA, 1'b0}, 1'b0);
    tx(8'h10, 1'b0);
    u_swe_master.sendBits(8'hFF, 3, n);
    u_swe_master.frame(1'b0);
    idleChk();
    chk({15'h0, nvmValid}, 16'h0, "no word");
    u_swe_master.frame(1'b1);
    tx({4'hA, 3'h1, 1'b0}, 1'b1);
    u_swe_master.frame(1'b0);
    slaveAddr = 3'h1;
    u_swe_master.frame(1'b1);
    tx({4'hE, 3'h1, 1'b1}, 1'b0);
    u_swe_master.frame(1'b0);
    slaveAddr = SA;
  endtask

  // User half of the security register, then the protected lower half
  task automatic sSec();
    words.delete();
    u_swe_master.frame(1'b1);
    tx({4'hB, SA, 1'b0}, 1'b0);
    tx(8'hF3, 1'b0);
    tx(8'h5A, 1'b0);
    u_swe_master.frame(1'b0);
    waitDone();
    chk(words[0], 16'h935A, "sec word");
    u_swe_master.frame(1'b1);
    tx({4'hB, SA, 1'b0}, 1'b0);
    tx(8'h05, 1'b0);
    tx(8'h00, 1'b1);
    u_swe_master.frame(1'b0);
    idleChk();
  endtask

  // Check, aborted lock, real lock, then behaviour once locked
  task automatic sLock();
    u_swe_master.frame(1'b1);
    tx({4'h2, SA, 1'b0}, 1'b0);
    tx(8'h60, 1'b0);
    u_swe_master.frame(1'b0);
    idleChk();
    u_swe_master.frame(1'b1);
    tx({4'h2, SA, 1'b0}, 1'b0);
    tx(8'h65, 1'b0);
    u_swe_master.sendBits(8'h00, 4, n);
    u_swe_master.frame(1'b0);
    idleChk();
    u_swe_master.frame(1'b1);
    tx({4'h2, SA, 1'b0}, 1'b0);
    tx(8'h6F, 1'b0);
    tx(8'h00, 1'b0);
    u_swe_master.frame(1'b0);
    waitDone();
    chk({15'h0, lp}, 16'h1, "lock pulse");
    secLockedNv = 1'b1;
    u_swe_master.frame(1'b1);
    tx({4'h2, SA, 1'b0}, 1'b0);
    tx(8'h60, 1'b1);
    u_swe_master.frame(1'b0);
    u_swe_master.frame(1'b1);
    tx({4'hB, SA, 1'b0}, 1'b0);
    tx(8'h13, 1'b0);
    tx(8'h11, 1'b1);
    u_swe_master.frame(1'b1);
    tx({4'hE, SA, 1'b1}, 1'b0);
    u_swe_master.frame(1'b0);
    secLockedNv = 1'b0;
  endtask

  // Every speed opcode both ways, then discovery reset
  task automatic sSpeed();
    for (int i = 0; i < 6; i++)
    begin
      u_swe_master.frame(1'b1);
      tx({SP_OP[i], SA, SP_RW[i]}, SP_NK[i]);
      chk({15'h0, speedSlow}, {15'h0, SP_SL[i]}, "speed");
      u_swe_master.frame(1'b0);
    end
    u_swe_master.frame(1'b1);
    tx({4'hD, SA, 1'b0}, 1'b0);
    u_swe_master.frame(1'b0);
    discoveryReset = 1'b1;
    @(negedge clk);
    discoveryReset = 1'b0;
    @(negedge clk);
    chk({15'h0, speedSlow}, 16'h0, "fast again");
  endtask

  // Pulse during the write cycle, then a discharge abort
  task automatic sBusy();
    nvmReady = 1'b0;
    u_swe_master.frame(1'b1);
    tx({4'hA, SA, 1'b0}, 1'b0);
    tx(8'h20, 1'b0);
    tx(8'h77, 1'b0);
    u_swe_master.frame(1'b0);
    repeat (3) @(negedge clk);
    u_swe_master.pulse();
    for (int k = 0; k < 4 && ackValid !== 1'b1; k++)
      @(negedge clk);
    chk({14'h0, ackValid, respNack}, 16'h3, "busy nack");
    dischargeAbort = 1'b1;
    @(negedge clk);
    dischargeAbort = 1'b0;
    for (int k = 0; k < 4 && wrAbort !== 1'b1; k++)
      @(negedge clk);
    chk({15'h0, wrAbort}, 16'h1, "abort");
    repeat (2) @(negedge clk);
    chk({15'h0, nvmValid}, 16'h0, "flushed");
    nvmReady = 1'b1;
    waitDone();
  endtask

  // --------------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------------
  initial
  begin
    reset_n        = 1'b0;
    slaveAddr      = SA;
    secLockedNv    = 1'b0;
    dischargeAbort = 1'b0;
    discoveryReset = 1'b0;
    nvmReady       = 1'b1;
    failures       = 0;
    checks         = 0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    chk({15'h0, speedSlow}, 16'h0, "reset speed");
    sPage();
    sAbort();
    sSec();
    sLock();
    sSpeed();
    sBusy();
    conclude();
  end

  // Whole run needs a few hundred cycles; allow far more
  initial
  begin
    #800000;
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
